// ### gpio_wake_pkg.sv
package gpio_wake_pkg;

  // ******************************
  // Register indices
  // ******************************
  localparam logic [4:0] IDX_GLOBAL_WAKE_STATUS = 5'h00;
  localparam logic [4:0] IDX_GLOBAL_WAKE_ENABLE = 5'h01;
  localparam logic [4:0] IDX_WAKE_STATUS_A      = 5'h02;
  localparam logic [4:0] IDX_WAKE_STATUS_B      = 5'h03;
  localparam logic [4:0] IDX_WAKE_ENABLE_A      = 5'h05;
  localparam logic [4:0] IDX_WAKE_ENABLE_B      = 5'h06;
  localparam logic [4:0] IDX_MGMT_STATUS_A      = 5'h08;
  localparam logic [4:0] IDX_MGMT_STATUS_B      = 5'h09;
  localparam logic [4:0] IDX_MGMT_ENABLE_A      = 5'h0a;
  localparam logic [4:0] IDX_MGMT_ENABLE_B      = 5'h0b;
  localparam logic [4:0] IDX_DATA_P1            = 5'h0c;
  localparam logic [4:0] IDX_DATA_P2            = 5'h0d;
  localparam logic [4:0] IDX_DATA_P4            = 5'h0f;
  localparam logic [4:0] IDX_DIR_P1             = 5'h10;
  localparam logic [4:0] IDX_DIR_P2             = 5'h11;
  localparam logic [4:0] IDX_DIR_P4             = 5'h12;
  localparam logic [4:0] IDX_POLARITY_ONE       = 5'h13;
  localparam logic [4:0] IDX_POLARITY_TWO       = 5'h14;
  localparam logic [4:0] IDX_POLARITY_P4        = 5'h15;
  localparam logic [4:0] IDX_OUTPUT_TYPE        = 5'h16;

  // ******************************
  // Field positions
  // ******************************
  localparam int BIT_SHARED_PIN     = 2;
  localparam int BIT_P2_PIN         = 3;
  localparam int BIT_RING           = 0;
  localparam int BIT_PARALLEL       = 0;
  localparam int BIT_SERIAL         = 1;
  localparam int BIT_SERIRQ_ROUTE   = 6;
  localparam int BIT_PIN_ROUTE      = 7;
  localparam int BIT_WAKE_POLARITY  = 5;
  localparam int BIT_WAKE_PUSH_PULL = 7;
  localparam int P1_WIDTH           = 5;
  localparam int P4_WIDTH           = 8;

  // ******************************
  // Reset values
  // ******************************
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_DIR_INPUT = 8'hff;

endpackage

// ### gpio_wake_smi_event_logic.sv
`timescale 1ns/1ns
module gpio_wake_smi_event_logic
  import gpio_wake_pkg::*;
(
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  // Avalon-MM slave
  input  wire logic [6:0]          address_i,
  input  wire logic                read_i,
  input  wire logic                write_i,
  input  wire logic [7:0]          writedata_i,
  output logic      [7:0]          readdata_o,
  output logic                     waitrequest_o,
  // Port one pins
  input  wire logic [P1_WIDTH-1:0] p1_pin_i,
  output logic      [P1_WIDTH-1:0] p1_pin_o,
  output logic      [P1_WIDTH-1:0] p1_pin_oe_o,
  // Port two pin
  input  wire logic                wake_pin_p2_3_i,
  output logic                     wake_pin_p2_3_o,
  output logic                     wake_pin_p2_3_oe_o,
  // Port four pins
  input  wire logic [P4_WIDTH-1:0] plain_port4_pins_i,
  output logic      [P4_WIDTH-1:0] plain_port4_pins_o,
  output logic      [P4_WIDTH-1:0] plain_port4_pins_oe_o,
  // Wake sources and peripheral management sources
  input  wire logic                ring_indicator_in_n_i,
  input  wire logic                parallel_irq_i,
  input  wire logic                serial_irq_i,
  // Wake output pin and serial interrupt slot
  output logic                     wake_out_pin_o,
  output logic                     wake_out_pin_oe_o,
  output logic                     serirq_irq2_o
);

  // ******************************
  // Registers
  // ******************************
  logic                global_wake_status;
  logic                global_wake_enable;
  logic [P1_WIDTH-1:0] wake_status_a;
  logic [7:0]          wake_status_b;
  logic [P1_WIDTH-1:0] wake_enable_a;
  logic [7:0]          wake_enable_b;
  logic [P1_WIDTH-1:0] mgmt_status_a;
  logic                mgmt_status_p2;
  logic [P1_WIDTH-1:0] mgmt_enable_a;
  logic [7:0]          mgmt_enable_b;
  logic [P1_WIDTH-1:0] out_p1;
  logic                out_p2;
  logic [P4_WIDTH-1:0] out_p4;
  logic [P1_WIDTH-1:0] dir_p1;
  logic                dir_p2;
  logic [P4_WIDTH-1:0] dir_p4;
  logic [7:0]          polarity_reg_one;
  logic [7:0]          polarity_reg_two;
  logic [P4_WIDTH-1:0] polarity_p4;
  logic [7:0]          output_type_reg;

  logic                next_global_wake_status;
  logic                next_global_wake_enable;
  logic [P1_WIDTH-1:0] next_wake_status_a;
  logic [7:0]          next_wake_status_b;
  logic [P1_WIDTH-1:0] next_wake_enable_a;
  logic [7:0]          next_wake_enable_b;
  logic [P1_WIDTH-1:0] next_mgmt_status_a;
  logic                next_mgmt_status_p2;
  logic [P1_WIDTH-1:0] next_mgmt_enable_a;
  logic [7:0]          next_mgmt_enable_b;
  logic [P1_WIDTH-1:0] next_out_p1;
  logic                next_out_p2;
  logic [P4_WIDTH-1:0] next_out_p4;
  logic [P1_WIDTH-1:0] next_dir_p1;
  logic                next_dir_p2;
  logic [P4_WIDTH-1:0] next_dir_p4;
  logic [7:0]          next_polarity_reg_one;
  logic [7:0]          next_polarity_reg_two;
  logic [P4_WIDTH-1:0] next_polarity_p4;
  logic [7:0]          next_output_type_reg;

  // Bus handshake
  logic                next_waitrequest;
  logic [7:0]          next_readdata;
  logic                request;
  logic                commit;
  logic                wr;
  logic [4:0]          index;

  // Synchronised pins and edges
  logic [P1_WIDTH-1:0] p1_level;
  logic [P1_WIDTH-1:0] p1_edge;
  logic                p2_level;
  logic                p2_edge;
  logic [P4_WIDTH-1:0] p4_level;
  logic                ring_level;
  logic                ring_edge;

  // Event combination
  logic                wake_pending;
  logic                wake_active;
  logic                grouped_mgmt_irq;
  logic                mgmt_pin_active;
  logic                shared_routed;
  logic [P1_WIDTH-1:0] p1_value;
  logic [P1_WIDTH-1:0] p1_drive;
  logic [P1_WIDTH-1:0] p1_push_pull;
  logic                wake_value;

  // ******************************
  // Pin synchronisers
  // ******************************
  pin_sync_edge #(.WIDTH(P1_WIDTH)) sync_p1 (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .pin_i    (p1_pin_i),
    .invert_i (polarity_reg_one[P1_WIDTH-1:0]),
    .level_o  (p1_level),
    .edge_o   (p1_edge)
  );

  pin_sync_edge #(.WIDTH(1)) sync_p2 (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .pin_i    (wake_pin_p2_3_i),
    .invert_i (polarity_reg_two[BIT_P2_PIN]),
    .level_o  (p2_level),
    .edge_o   (p2_edge)
  );

  // Port four: level only, no event logic
  pin_sync_edge #(.WIDTH(P4_WIDTH)) sync_p4 (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .pin_i    (plain_port4_pins_i),
    .invert_i (polarity_p4),
    .level_o  (p4_level),
    .edge_o   ()
  );

  // Ring indicator is active low: falling transition
  pin_sync_edge #(.WIDTH(1)) sync_ring (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .pin_i    (ring_indicator_in_n_i),
    .invert_i (1'b1),
    .level_o  (ring_level),
    .edge_o   (ring_edge)
  );

  // ******************************
  // Bus decode and register update
  // ******************************
  always_comb
  begin
    request    = read_i | write_i;
    commit     = request & ~waitrequest_o;
    wr         = write_i & commit;
    index      = address_i[6:2];

    next_waitrequest = ~(request & waitrequest_o);

    next_global_wake_enable = global_wake_enable;
    next_wake_enable_a      = wake_enable_a;
    next_wake_enable_b      = wake_enable_b;
    next_mgmt_enable_a      = mgmt_enable_a;
    next_mgmt_enable_b      = mgmt_enable_b;
    next_out_p1             = out_p1;
    next_out_p2             = out_p2;
    next_out_p4             = out_p4;
    next_dir_p1             = dir_p1;
    next_dir_p2             = dir_p2;
    next_dir_p4             = dir_p4;
    next_polarity_reg_one   = polarity_reg_one;
    next_polarity_reg_two   = polarity_reg_two;
    next_polarity_p4        = polarity_p4;
    next_output_type_reg    = output_type_reg;

    // Sticky status: set wins over write-one clear
    next_wake_status_a  = wake_status_a | p1_edge;
    next_wake_status_b  = wake_status_b;
    next_wake_status_b[BIT_P2_PIN] = wake_status_b[BIT_P2_PIN] | p2_edge;
    next_wake_status_b[BIT_RING]   = wake_status_b[BIT_RING] | ring_edge;
    next_mgmt_status_a  = mgmt_status_a | p1_edge;
    next_mgmt_status_p2 = mgmt_status_p2 | p2_edge;

    if (wr)
    begin
      unique case (index)
        IDX_WAKE_STATUS_A:
          next_wake_status_a = wake_status_a & ~writedata_i[P1_WIDTH-1:0] | p1_edge;
        IDX_WAKE_STATUS_B:
        begin
          next_wake_status_b[BIT_P2_PIN] =
            wake_status_b[BIT_P2_PIN] & ~writedata_i[BIT_P2_PIN] | p2_edge;
          next_wake_status_b[BIT_RING] =
            wake_status_b[BIT_RING] & ~writedata_i[BIT_RING] | ring_edge;
        end
        IDX_MGMT_STATUS_A:
          next_mgmt_status_a = mgmt_status_a & ~writedata_i[P1_WIDTH-1:0] | p1_edge;
        IDX_MGMT_STATUS_B:
          next_mgmt_status_p2 = mgmt_status_p2 & ~writedata_i[BIT_P2_PIN] | p2_edge;
        IDX_GLOBAL_WAKE_ENABLE: next_global_wake_enable = writedata_i[0];
        IDX_WAKE_ENABLE_A:      next_wake_enable_a = writedata_i[P1_WIDTH-1:0];
        IDX_WAKE_ENABLE_B:      next_wake_enable_b = writedata_i;
        IDX_MGMT_ENABLE_A:      next_mgmt_enable_a = writedata_i[P1_WIDTH-1:0];
        IDX_MGMT_ENABLE_B:      next_mgmt_enable_b = writedata_i;
        IDX_DATA_P1:
          next_out_p1 = (writedata_i[P1_WIDTH-1:0] & ~dir_p1) | (out_p1 & dir_p1);
        IDX_DATA_P2:
          next_out_p2 = dir_p2 ? out_p2 : writedata_i[BIT_P2_PIN];
        IDX_DATA_P4:
          next_out_p4 = (writedata_i & ~dir_p4) | (out_p4 & dir_p4);
        IDX_DIR_P1:             next_dir_p1 = writedata_i[P1_WIDTH-1:0];
        IDX_DIR_P2:             next_dir_p2 = writedata_i[BIT_P2_PIN];
        IDX_DIR_P4:             next_dir_p4 = writedata_i;
        IDX_POLARITY_ONE:       next_polarity_reg_one = writedata_i;
        IDX_POLARITY_TWO:       next_polarity_reg_two = writedata_i;
        IDX_POLARITY_P4:        next_polarity_p4 = writedata_i;
        IDX_OUTPUT_TYPE:        next_output_type_reg = writedata_i;
        default:                ;
      endcase
    end

    // Global status: set while pending, held until a write of one clears it with nothing pending
    wake_pending = |(next_wake_status_a & wake_enable_a)
                 | (next_wake_status_b[BIT_P2_PIN] & wake_enable_b[BIT_P2_PIN])
                 | (next_wake_status_b[BIT_RING] & wake_enable_b[BIT_RING]);
    next_global_wake_status = wake_pending
      | (global_wake_status & ~(wr & index == IDX_GLOBAL_WAKE_STATUS & writedata_i[0]));
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      waitrequest_o      <= 1'b1;
      global_wake_status <= 1'b0;
      global_wake_enable <= 1'b0;
      wake_status_a      <= RST_ZERO[P1_WIDTH-1:0];
      wake_status_b      <= RST_ZERO;
      wake_enable_a      <= RST_ZERO[P1_WIDTH-1:0];
      wake_enable_b      <= RST_ZERO;
      mgmt_status_a      <= RST_ZERO[P1_WIDTH-1:0];
      mgmt_status_p2     <= 1'b0;
      mgmt_enable_a      <= RST_ZERO[P1_WIDTH-1:0];
      mgmt_enable_b      <= RST_ZERO;
      out_p1             <= RST_ZERO[P1_WIDTH-1:0];
      out_p2             <= 1'b0;
      out_p4             <= RST_ZERO;
      dir_p1             <= RST_DIR_INPUT[P1_WIDTH-1:0];
      dir_p2             <= 1'b1;
      dir_p4             <= RST_DIR_INPUT;
      polarity_reg_one   <= RST_ZERO;
      polarity_reg_two   <= RST_ZERO;
      polarity_p4        <= RST_ZERO;
      output_type_reg    <= RST_ZERO;
    end
    else
    begin
      waitrequest_o      <= next_waitrequest;
      global_wake_status <= next_global_wake_status;
      global_wake_enable <= next_global_wake_enable;
      wake_status_a      <= next_wake_status_a;
      wake_status_b      <= next_wake_status_b;
      wake_enable_a      <= next_wake_enable_a;
      wake_enable_b      <= next_wake_enable_b;
      mgmt_status_a      <= next_mgmt_status_a;
      mgmt_status_p2     <= next_mgmt_status_p2;
      mgmt_enable_a      <= next_mgmt_enable_a;
      mgmt_enable_b      <= next_mgmt_enable_b;
      out_p1             <= next_out_p1;
      out_p2             <= next_out_p2;
      out_p4             <= next_out_p4;
      dir_p1             <= next_dir_p1;
      dir_p2             <= next_dir_p2;
      dir_p4             <= next_dir_p4;
      polarity_reg_one   <= next_polarity_reg_one;
      polarity_reg_two   <= next_polarity_reg_two;
      polarity_p4        <= next_polarity_p4;
      output_type_reg    <= next_output_type_reg;
    end
  end

  // ******************************
  // Read data
  // ******************************
  always_comb
  begin
    next_readdata = readdata_o;
    if (read_i & waitrequest_o)
    begin
      next_readdata = 8'h00;
      unique case (index)
        IDX_GLOBAL_WAKE_STATUS: next_readdata[0] = global_wake_status;
        IDX_GLOBAL_WAKE_ENABLE: next_readdata[0] = global_wake_enable;
        IDX_WAKE_STATUS_A:      next_readdata[P1_WIDTH-1:0] = wake_status_a;
        IDX_WAKE_STATUS_B:      next_readdata = wake_status_b;
        IDX_WAKE_ENABLE_A:      next_readdata[P1_WIDTH-1:0] = wake_enable_a;
        IDX_WAKE_ENABLE_B:      next_readdata = wake_enable_b;
        IDX_MGMT_STATUS_A:      next_readdata[P1_WIDTH-1:0] = mgmt_status_a;
        IDX_MGMT_STATUS_B:
        begin
          next_readdata[BIT_PARALLEL] = parallel_irq_i;
          next_readdata[BIT_SERIAL]   = serial_irq_i;
          next_readdata[BIT_P2_PIN]   = mgmt_status_p2;
        end
        IDX_MGMT_ENABLE_A:      next_readdata[P1_WIDTH-1:0] = mgmt_enable_a;
        IDX_MGMT_ENABLE_B:      next_readdata = mgmt_enable_b;
        IDX_DATA_P1:
          next_readdata[P1_WIDTH-1:0] =
            (dir_p1 & (p1_level ^ polarity_reg_one[P1_WIDTH-1:0])) | (~dir_p1 & out_p1);
        IDX_DATA_P2:
          next_readdata[BIT_P2_PIN] =
            dir_p2 ? p2_level ^ polarity_reg_two[BIT_P2_PIN] : out_p2;
        IDX_DATA_P4:
          next_readdata = (dir_p4 & (p4_level ^ polarity_p4)) | (~dir_p4 & out_p4);
        IDX_DIR_P1:             next_readdata[P1_WIDTH-1:0] = dir_p1;
        IDX_DIR_P2:             next_readdata[BIT_P2_PIN] = dir_p2;
        IDX_DIR_P4:             next_readdata = dir_p4;
        IDX_POLARITY_ONE:       next_readdata = polarity_reg_one;
        IDX_POLARITY_TWO:       next_readdata = polarity_reg_two;
        IDX_POLARITY_P4:        next_readdata = polarity_p4;
        IDX_OUTPUT_TYPE:        next_readdata = output_type_reg;
        default:                next_readdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      readdata_o <= 8'h00;
    else
      readdata_o <= next_readdata;
  end

  // ******************************
  // Event outputs
  // ******************************
  always_comb
  begin
    wake_active      = global_wake_status & global_wake_enable;
    grouped_mgmt_irq = |(mgmt_status_a & mgmt_enable_a)
                     | (mgmt_status_p2 & mgmt_enable_b[BIT_P2_PIN])
                     | (parallel_irq_i & mgmt_enable_b[BIT_PARALLEL])
                     | (serial_irq_i & mgmt_enable_b[BIT_SERIAL]);
    shared_routed    = mgmt_enable_b[BIT_PIN_ROUTE];
    mgmt_pin_active  = grouped_mgmt_irq;
    // Active low unless polarity bit set
    wake_value       = polarity_reg_two[BIT_WAKE_POLARITY] ? wake_active : ~wake_active;

    p1_value     = out_p1 ^ polarity_reg_one[P1_WIDTH-1:0];
    p1_drive     = ~dir_p1;
    p1_push_pull = {output_type_reg[P1_WIDTH-1:BIT_SHARED_PIN], 2'b11};
    if (shared_routed)
    begin
      p1_value[BIT_SHARED_PIN] = polarity_reg_one[BIT_SHARED_PIN] ? mgmt_pin_active
                                                                  : ~mgmt_pin_active;
      p1_drive[BIT_SHARED_PIN] = 1'b1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      serirq_irq2_o <= 1'b0;
    else
      serirq_irq2_o <= grouped_mgmt_irq & mgmt_enable_b[BIT_SERIRQ_ROUTE];
  end

  // ******************************
  // Pin drivers
  // ******************************
  pin_driver #(.WIDTH(P1_WIDTH)) drive_p1 (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .value_i     (p1_value),
    .drive_i     (p1_drive),
    .push_pull_i (p1_push_pull),
    .out_o       (p1_pin_o),
    .oe_o        (p1_pin_oe_o)
  );

  pin_driver #(.WIDTH(1)) drive_p2 (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .value_i     (out_p2 ^ polarity_reg_two[BIT_P2_PIN]),
    .drive_i     (~dir_p2),
    .push_pull_i (1'b1),
    .out_o       (wake_pin_p2_3_o),
    .oe_o        (wake_pin_p2_3_oe_o)
  );

  pin_driver #(.WIDTH(P4_WIDTH)) drive_p4 (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .value_i     (out_p4 ^ polarity_p4),
    .drive_i     (~dir_p4),
    .push_pull_i (8'hff),
    .out_o       (plain_port4_pins_o),
    .oe_o        (plain_port4_pins_oe_o)
  );

  pin_driver #(.WIDTH(1)) drive_wake (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .value_i     (wake_value),
    .drive_i     (1'b1),
    .push_pull_i (output_type_reg[BIT_WAKE_PUSH_PULL]),
    .out_o       (wake_out_pin_o),
    .oe_o        (wake_out_pin_oe_o)
  );

endmodule // gpio_wake_smi_event_logic

// ### gw_asserts.sv
`timescale 1ns/1ns
module gw_asserts
  import gpio_wake_pkg::*;
(
  // Clock, reset and bus
  input wire logic                clock_i,
  input wire logic                rst_i,
  input wire logic                read_i,
  input wire logic                write_i,
  input wire logic                waitrequest_o,
  input wire logic [7:0]          readdata_o,
  // Pins
  input wire logic [P1_WIDTH-1:0] p1_pin_o,
  input wire logic [P1_WIDTH-1:0] p1_pin_oe_o,
  input wire logic                wake_pin_p2_3_o,
  input wire logic                wake_pin_p2_3_oe_o,
  input wire logic [P4_WIDTH-1:0] plain_port4_pins_o,
  input wire logic [P4_WIDTH-1:0] plain_port4_pins_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic wr_done;
  assign wr_done = write_i && !waitrequest_o;
  property p_wait_ans;
    (read_i || write_i) && waitrequest_o |=> !waitrequest_o;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no answer");
  property p_wait_one;
    !waitrequest_o |=> waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer too long");
  property p_wait_req;
    !waitrequest_o |-> read_i || write_i;
  endproperty
  a_wait_req: assert property (p_wait_req) else $error("answer without request");
  property p_rd_hold;
    $changed(readdata_o) |-> read_i && !waitrequest_o;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_p1_out;
    $changed({p1_pin_o[4:3], p1_pin_o[1:0]}) |-> $past(wr_done, 2);
  endproperty
  a_p1_out: assert property (p_p1_out) else $error("p1 value moved");
  property p_p1_oe;
    $changed({p1_pin_oe_o[4:3], p1_pin_oe_o[1:0]}) |-> $past(wr_done, 2);
  endproperty
  a_p1_oe: assert property (p_p1_oe) else $error("p1 enable moved");
  property p_p2;
    $changed({wake_pin_p2_3_o, wake_pin_p2_3_oe_o}) |-> $past(wr_done, 2);
  endproperty
  a_p2: assert property (p_p2) else $error("p2 pin moved");
  property p_p4;
    $changed({plain_port4_pins_o, plain_port4_pins_oe_o}) |-> $past(wr_done, 2);
  endproperty
  a_p4: assert property (p_p4) else $error("p4 pins moved");
  c_rd: cover property (read_i && !waitrequest_o);
  c_wr: cover property (wr_done);
  c_oe: cover property ($rose(p1_pin_oe_o[0]));
endmodule // gw_asserts
bind gpio_wake_smi_event_logic gw_asserts u_chk (.clock_i, .rst_i, .read_i, .write_i,
  .waitrequest_o, .readdata_o, .p1_pin_o, .p1_pin_oe_o, .wake_pin_p2_3_o,
  .wake_pin_p2_3_oe_o, .plain_port4_pins_o, .plain_port4_pins_oe_o);

// ### gw_chipset.sv
`timescale 1ns/1ns
module gw_chipset
(
  // Wake driver of the block
  input  wire logic wake_out_i,
  input  wire logic wake_oe_i,
  // Level seen on the pulled-up line
  output logic      wake_line_o
);
  assign wake_line_o = wake_oe_i ? wake_out_i : 1'b1;
endmodule // gw_chipset

// ### pin_driver.sv
`timescale 1ns/1ns
module pin_driver
  import gpio_wake_pkg::*;
#(
  parameter int WIDTH = 1
)(
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  // Requested level and driver mode
  input  wire logic [WIDTH-1:0] value_i,
  input  wire logic [WIDTH-1:0] drive_i,
  input  wire logic [WIDTH-1:0] push_pull_i,
  // Pin output and enable
  output logic      [WIDTH-1:0] out_o,
  output logic      [WIDTH-1:0] oe_o
);

  logic [WIDTH-1:0] next_out;
  logic [WIDTH-1:0] next_oe;

  // Open-drain only drives the low level
  always_comb
  begin
    next_out = value_i;
    next_oe  = drive_i & (push_pull_i | ~value_i);
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      out_o <= '0;
      oe_o  <= '0;
    end
    else
    begin
      out_o <= next_out;
      oe_o  <= next_oe;
    end
  end

endmodule // pin_driver

// ### pin_sync_edge.sv
`timescale 1ns/1ns
module pin_sync_edge
  import gpio_wake_pkg::*;
#(
  parameter int WIDTH = 1
)(
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  // Pins and edge selection
  input  wire logic [WIDTH-1:0] pin_i,
  input  wire logic [WIDTH-1:0] invert_i,
  // Synchronised level and selected edge
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] edge_o
);

  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] stage_two;
  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_prev;

  always_comb
  begin
    next_prev = stage_two;
    level_o   = stage_two;
    edge_o    = (stage_two ^ invert_i) & ~(prev ^ invert_i);
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      stage_one <= '0;
      stage_two <= '0;
      prev      <= '0;
    end
    else
    begin
      stage_one <= pin_i;
      stage_two <= stage_one;
      prev      <= next_prev;
    end
  end

endmodule // pin_sync_edge

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
  import gpio_wake_pkg::*;
  logic clock_i, rst_i, read_i, write_i, par, p2_in, ri_n;
  logic [6:0] address_i;
  logic [7:0] writedata_i, rdv;
  logic [4:0] p1_ext;
  wire logic [7:0] readdata_o, p4_o, p4_oe;
  wire logic waitrequest_o, p2_o, p2_oe, wk_o, wk_oe, irq2, wk;
  wire logic [4:0] p1_o, p1_oe, p1_lvl;
  int mismatches, compares;
  assign p1_lvl = (p1_oe & p1_o) | (~p1_oe & p1_ext);
  gpio_wake_smi_event_logic uut (.clock_i, .rst_i, .address_i, .read_i, .write_i,
    .writedata_i, .readdata_o, .waitrequest_o, .p1_pin_i(p1_lvl), .p1_pin_o(p1_o),
    .p1_pin_oe_o(p1_oe), .wake_pin_p2_3_i(p2_in), .wake_pin_p2_3_o(p2_o),
    .wake_pin_p2_3_oe_o(p2_oe), .plain_port4_pins_i(8'hff), .plain_port4_pins_o(p4_o),
    .plain_port4_pins_oe_o(p4_oe), .ring_indicator_in_n_i(ri_n), .parallel_irq_i(par),
    .serial_irq_i(1'b0), .wake_out_pin_o(wk_o), .wake_out_pin_oe_o(wk_oe),
    .serirq_irq2_o(irq2));
  gw_chipset u_cs (.wake_out_i(wk_o), .wake_oe_i(wk_oe), .wake_line_o(wk));
  initial
  begin
    clock_i = 0;
    forever #50 clock_i = ~clock_i;
  end
  task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task acc(input logic w, input logic [4:0] idx, input logic [7:0] d);
    @(posedge clock_i);
    address_i <= {idx, 2'b00};
    writedata_i <= d;
    read_i <= !w;
    write_i <= w;
    do @(posedge clock_i); while (waitrequest_o !== 1'b0);
    rdv = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask
  task rd(input string n, input logic [4:0] idx, input logic [7:0] e);
    acc(1'b0, idx, 8'h00);
    chk(n, rdv, e);
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  initial
  begin
    tick(3000);
    mismatches++;
    conclude();
  end
  initial
  begin
    {rst_i, read_i, write_i, par, p2_in, ri_n} = 6'h21;
    {address_i, writedata_i, p1_ext} = '0;
    tick(8);
    rst_i <= 1'b0;
    acc(1, IDX_OUTPUT_TYPE, 8'h1c);
    rd("p4_in", IDX_DATA_P4, 8'hff);
    acc(1, IDX_DIR_P1, 8'h00);
    acc(1, IDX_DATA_P1, 8'h15);
    acc(1, IDX_POLARITY_ONE, 8'h01);
    acc(1, IDX_DIR_P4, 8'h00);
    acc(1, IDX_DATA_P4, 8'ha5);
    tick(2);
    chk("p1_out", {3'h0, p1_o}, 8'h14);
    chk("p1_oe", {3'h0, p1_oe}, 8'h1f);
    chk("p4_out", p4_o, 8'ha5);
    rd("p1_last", IDX_DATA_P1, 8'h15);
    acc(1, IDX_DIR_P1, 8'h1f);
    p1_ext <= 5'h0a;
    tick(4);
    rd("p1_in", IDX_DATA_P1, 8'h0b);
    acc(1, IDX_DATA_P1, 8'h00);
    rd("p1_in_wr", IDX_DATA_P1, 8'h0b);
    chk("p1_oe_in", {3'h0, p1_oe}, 8'h00);
    $display("Test data path done");
    p1_ext <= 5'h00;
    acc(1, IDX_POLARITY_ONE, 8'h00);
    tick(4);
    acc(1, IDX_WAKE_STATUS_A, 8'h1f);
    acc(1, IDX_MGMT_STATUS_A, 8'h1f);
    acc(1, IDX_WAKE_ENABLE_A, 8'h01);
    p1_ext <= 5'h01;
    tick(6);
    rd("wake_sts", IDX_WAKE_STATUS_A, 8'h01);
    rd("glob_sts", IDX_GLOBAL_WAKE_STATUS, 8'h01);
    chk("wake_idle", {7'h0, wk}, 8'h01);
    acc(1, IDX_GLOBAL_WAKE_ENABLE, 8'h01);
    tick(3);
    chk("wake_on", {7'h0, wk}, 8'h00);
    p1_ext <= 5'h00;
    acc(1, IDX_WAKE_STATUS_A, 8'h00);
    acc(1, IDX_GLOBAL_WAKE_STATUS, 8'h01);
    rd("sts_hold", IDX_WAKE_STATUS_A, 8'h01);
    rd("glob_hold", IDX_GLOBAL_WAKE_STATUS, 8'h01);
    acc(1, IDX_WAKE_STATUS_A, 8'h01);
    acc(1, IDX_GLOBAL_WAKE_STATUS, 8'h01);
    tick(3);
    rd("fall_none", IDX_WAKE_STATUS_A, 8'h00);
    rd("glob_clr", IDX_GLOBAL_WAKE_STATUS, 8'h00);
    chk("wake_off", {7'h0, wk}, 8'h01);
    $display("Test wake done");
    acc(1, IDX_MGMT_ENABLE_A, 8'h02);
    acc(1, IDX_MGMT_ENABLE_B, 8'h40);
    p1_ext <= 5'h02;
    tick(6);
    chk("irq2_pin", {7'h0, irq2}, 8'h01);
    acc(1, IDX_MGMT_STATUS_A, 8'h02);
    tick(3);
    chk("irq2_clr", {7'h0, irq2}, 8'h00);
    acc(1, IDX_MGMT_ENABLE_B, 8'h41);
    par <= 1'b1;
    tick(3);
    chk("irq2_par", {7'h0, irq2}, 8'h01);
    acc(1, IDX_MGMT_STATUS_B, 8'h01);
    tick(2);
    chk("irq2_w1c", {7'h0, irq2}, 8'h01);
    par <= 1'b0;
    tick(3);
    chk("irq2_src", {7'h0, irq2}, 8'h00);
    acc(1, IDX_MGMT_ENABLE_B, 8'h81);
    par <= 1'b1;
    tick(3);
    chk("smi_pin", {6'h0, p1_o[2], p1_oe[2]}, 8'h01);
    acc(1, IDX_WAKE_ENABLE_B, 8'h09);
    {ri_n, p2_in} <= 2'b01;
    tick(4);
    rd("wake_b", IDX_WAKE_STATUS_B, 8'h09);
    rd("mgmt_b", IDX_MGMT_STATUS_B, 8'h09);
    $display("Test management done");
    conclude();
  end
endmodule // testbench
